// file: pkg/omsc_pkg.sv
// Package for the output mute / source select register bank.
// Assumes a 16-bit register port with 8-bit word addresses.
package omsc_pkg;

    // Register addresses (word index on the plain port)
    localparam logic [7:0]  OMSC_ADDR_MUTE_SWING  = 8'h43;
    localparam logic [7:0]  OMSC_ADDR_RESERVED_A_A      = 8'h44;
    localparam logic [7:0]  OMSC_ADDR_RESERVED_A_B      = 8'h45;
    localparam logic [7:0]  OMSC_ADDR_RESERVED_A_C      = 8'h46;
    localparam logic [7:0]  OMSC_ADDR_RESERVED_A_D      = 8'h47;
    localparam logic [7:0]  OMSC_ADDR_SRC_SEL     = 8'h48;
    localparam logic [7:0]  OMSC_ADDR_MUTE_CTRL   = 8'h49;

    // Reset values of whole registers
    localparam logic [15:0] OMSC_RST_MUTE_SWING   = 16'h0850;
    localparam logic [15:0] OMSC_RST_RESERVED_A_A       = 16'h0342;
    localparam logic [15:0] OMSC_RST_RESERVED_A_B       = 16'h1c90;
    localparam logic [15:0] OMSC_RST_RESERVED_A_C       = 16'h0342;
    localparam logic [15:0] OMSC_RST_RESERVED_A_D       = 16'h1c90;
    localparam logic [15:0] OMSC_RST_SRC_SEL      = 16'h0100;
    localparam logic [15:0] OMSC_RST_MUTE_CTRL    = 16'h0005;

    // Field positions, source select register
    localparam int OMSC_SEL_OUT1_SRC   = 0;
    localparam int OMSC_SEL_OUT0_SRC   = 1;
    localparam int OMSC_SEL_OUT1_INV   = 2;
    localparam int OMSC_SEL_OUT0_INV   = 3;

    // Field positions, mute control register
    localparam int OMSC_MC_OUT0_AUTO   = 0;
    localparam int OMSC_MC_OUT0_MAN    = 1;
    localparam int OMSC_MC_OUT1_AUTO   = 2;
    localparam int OMSC_MC_OUT1_MAN    = 3;
    localparam int OMSC_MC_OUT0_UNLK   = 4;
    localparam int OMSC_MC_OUT1_UNLK   = 5;

    // Swing field position
    localparam int OMSC_SWING_LSB      = 8;
    localparam int OMSC_SWING_MSB      = 13;

    // Per-output control bundle
    typedef struct packed {
        logic       src_prbs;
        logic       invert;
        logic       auto_mode;
        logic       manual_silence;
        logic       unlock_silence;
    } omsc_out_ctl_s;

endpackage : omsc_pkg

// file: hw/omsc_out_path.sv
// One serial output's source select, polarity and mute decision.
// Assumes data, generator and status inputs synchronous to mclk.
`timescale 1ns/1ps
module omsc_out_path
    import omsc_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire omsc_out_ctl_s ctl,
    input  wire logic          retimed_bit,
    input  wire logic          prbs_bit,
    input  wire logic          signal_lost,
    input  wire logic          cdr_locked,
    output logic               serial_out,
    output logic               silenced
);

    logic mute_nxt;
    logic out_nxt;

    // Mute decision: auto mode follows signal loss and optional unlock
    always_comb
    begin
        if (ctl.auto_mode)
            mute_nxt = signal_lost | (ctl.unlock_silence & ~cdr_locked);
        else
            mute_nxt = ctl.manual_silence | (ctl.unlock_silence & ~cdr_locked);
    end

    // Source and polarity; inversion only touches re-timed data
    always_comb
    begin
        if (ctl.src_prbs)
            out_nxt = prbs_bit;
        else
            out_nxt = retimed_bit ^ ctl.invert;
    end

    // Registered outputs; a muted output holds the latch level low
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            serial_out <= 1'b0;
            silenced   <= 1'b1;
        end
        else
        begin
            silenced   <= mute_nxt;
            serial_out <= mute_nxt ? 1'b0 : out_nxt;
        end
    end

endmodule : omsc_out_path

// file: hw/omsc_top.sv
// Register bank steering the two serial trace-driver outputs.
// Assumes a single-cycle strobe register port and one clock mclk.
`timescale 1ns/1ps
// How it works
// - Output 0 carries re-timed data when its select bit 1 is 0 and the generator signal when it is 1.
// - Output 1 carries re-timed data when select bit 0 is 0 and the generator signal when 1, reset 0.
// - Output 0 is inverted when bit 3 is set, but only while it carries data.
// - Output 1 is inverted when bit 2 is set, but only while it carries data.
// - With auto mode off, manual bit 1 mutes output 0 when set.
// - With auto mode off, manual bit 3 mutes output 1 when set.
// - Mode bit 0 picks auto muting of output 0 when 1, manual when 0, reset 1.
// - Mode bit 2 picks auto muting of output 1 when 1, manual when 0, reset 1.
// - Bit 5 set mutes output 1 whenever clock recovery is unlocked.
// - Bit 4 set mutes output 0 whenever clock recovery is unlocked.
// - Bits 13:8 hold output 0 mute latch swing, 0 to 63, reset 8.
module omsc_top
    import omsc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        retimed_bit,
    input  wire logic        prbs_bit,
    input  wire logic        signal_lost,
    input  wire logic        cdr_locked,
    output logic             serial_out_zero,
    output logic             serial_out_one,
    output logic             out0_silenced,
    output logic             out1_silenced,
    output logic      [5:0]  out0_mute_latch_swing
);

    logic [15:0]   mute_swing_r;
    logic [15:0]   reserved_a_r [4];
    logic [15:0]   src_sel_r;
    logic [15:0]   mute_ctrl_r;
    logic [15:0]   rdata_nxt;
    omsc_out_ctl_s ctl0;
    omsc_out_ctl_s ctl1;

    localparam logic [15:0] RESERVED_A_RST [4] = '{OMSC_RST_RESERVED_A_A, OMSC_RST_RESERVED_A_B,
                                             OMSC_RST_RESERVED_A_C, OMSC_RST_RESERVED_A_D};

    // Swing register; whole word stored so reserved bits read back
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            mute_swing_r <= OMSC_RST_MUTE_SWING;
        else if (reg_wr && reg_addr == OMSC_ADDR_MUTE_SWING)
            mute_swing_r <= reg_wdata;
    end

    // Reserved registers are plain storage; software keeps them unchanged
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_reserved_a
            always_ff @(posedge mclk)
            begin
                if (!nrst)
                    reserved_a_r[gi] <= RESERVED_A_RST[gi];
                else if (reg_wr && reg_addr == OMSC_ADDR_RESERVED_A_A + 8'(gi))
                    reserved_a_r[gi] <= reg_wdata;
            end
        end
    endgenerate

    // Source select register
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            src_sel_r <= OMSC_RST_SRC_SEL;
        else if (reg_wr && reg_addr == OMSC_ADDR_SRC_SEL)
            src_sel_r <= reg_wdata;
    end

    // Mute control register; auto modes come up enabled
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            mute_ctrl_r <= OMSC_RST_MUTE_CTRL;
        else if (reg_wr && reg_addr == OMSC_ADDR_MUTE_CTRL)
            mute_ctrl_r <= reg_wdata;
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (reg_addr)
            OMSC_ADDR_MUTE_SWING: rdata_nxt = mute_swing_r;
            OMSC_ADDR_RESERVED_A_A:     rdata_nxt = reserved_a_r[0];
            OMSC_ADDR_RESERVED_A_B:     rdata_nxt = reserved_a_r[1];
            OMSC_ADDR_RESERVED_A_C:     rdata_nxt = reserved_a_r[2];
            OMSC_ADDR_RESERVED_A_D:     rdata_nxt = reserved_a_r[3];
            OMSC_ADDR_SRC_SEL:    rdata_nxt = src_sel_r;
            OMSC_ADDR_MUTE_CTRL:  rdata_nxt = mute_ctrl_r;
            default:              rdata_nxt = 16'h0000;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 16'h0000;
    end

    // Swing field goes to the analog mute latch
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            out0_mute_latch_swing <= OMSC_RST_MUTE_SWING[OMSC_SWING_MSB:OMSC_SWING_LSB];
        else
            out0_mute_latch_swing <= mute_swing_r[OMSC_SWING_MSB:OMSC_SWING_LSB];
    end

    // Per-output control bundles
    always_comb
    begin
        ctl0.src_prbs       = src_sel_r[OMSC_SEL_OUT0_SRC];
        ctl0.invert         = src_sel_r[OMSC_SEL_OUT0_INV];
        ctl0.auto_mode      = mute_ctrl_r[OMSC_MC_OUT0_AUTO];
        ctl0.manual_silence = mute_ctrl_r[OMSC_MC_OUT0_MAN];
        ctl0.unlock_silence = mute_ctrl_r[OMSC_MC_OUT0_UNLK];
        ctl1.src_prbs       = src_sel_r[OMSC_SEL_OUT1_SRC];
        ctl1.invert         = src_sel_r[OMSC_SEL_OUT1_INV];
        ctl1.auto_mode      = mute_ctrl_r[OMSC_MC_OUT1_AUTO];
        ctl1.manual_silence = mute_ctrl_r[OMSC_MC_OUT1_MAN];
        ctl1.unlock_silence = mute_ctrl_r[OMSC_MC_OUT1_UNLK];
    end

    // Output 0 path
    omsc_out_path u_out0 (
        .mclk        (mclk),
        .nrst        (nrst),
        .ctl         (ctl0),
        .retimed_bit (retimed_bit),
        .prbs_bit    (prbs_bit),
        .signal_lost (signal_lost),
        .cdr_locked  (cdr_locked),
        .serial_out  (serial_out_zero),
        .silenced    (out0_silenced)
    );

    // Output 1 path
    omsc_out_path u_out1 (
        .mclk        (mclk),
        .nrst        (nrst),
        .ctl         (ctl1),
        .retimed_bit (retimed_bit),
        .prbs_bit    (prbs_bit),
        .signal_lost (signal_lost),
        .cdr_locked  (cdr_locked),
        .serial_out  (serial_out_one),
        .silenced    (out1_silenced)
    );

endmodule : omsc_top

// file: dv/omsc_top_sva.sv
// Checker for the output mute/select bank, port relations only.
// Assumes it is bound onto omsc_top, one clock, sync reset.
`timescale 1ns/1ps
module omsc_chk
    import omsc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        retimed_bit,
    input wire logic        prbs_bit,
    input wire logic        signal_lost,
    input wire logic        cdr_locked,
    input wire logic        serial_out_zero,
    input wire logic        serial_out_one,
    input wire logic        out0_silenced,
    input wire logic        out1_silenced,
    input wire logic [5:0]  out0_mute_latch_swing
);
    logic [15:0] sel_r;
    logic [15:0] mc_r;
    logic [5:0]  sw_r;
    logic        m0;
    logic        m1;
    logic        d0;
    logic        d1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Shadow copies of the control words, so outputs can be predicted
    always_ff @(posedge mclk)
        sel_r <= !nrst ? OMSC_RST_SRC_SEL : (reg_wr && reg_addr == OMSC_ADDR_SRC_SEL) ? reg_wdata : sel_r;
    always_ff @(posedge mclk)
        mc_r <= !nrst ? OMSC_RST_MUTE_CTRL : (reg_wr && reg_addr == OMSC_ADDR_MUTE_CTRL) ? reg_wdata : mc_r;
    always_ff @(posedge mclk)
        sw_r <= !nrst ? 6'h08 : (reg_wr && reg_addr == OMSC_ADDR_MUTE_SWING) ? reg_wdata[13:8] : sw_r;
    // Unlock muting is ORed in whatever the mode
    assign m0 = (mc_r[0] ? signal_lost : mc_r[1]) | (mc_r[4] & ~cdr_locked);
    assign m1 = (mc_r[2] ? signal_lost : mc_r[3]) | (mc_r[5] & ~cdr_locked);
    assign d0 = sel_r[1] ? prbs_bit : retimed_bit ^ sel_r[3];
    assign d1 = sel_r[0] ? prbs_bit : retimed_bit ^ sel_r[2];
    mute0_follow_a: assert property ($past(nrst) |-> out0_silenced == $past(m0))
        else $error("output 0 mute flag wrong");
    mute1_follow_a: assert property ($past(nrst) |-> out1_silenced == $past(m1))
        else $error("output 1 mute flag wrong");
    data0_route_a: assert property ($past(nrst) && !out0_silenced |-> serial_out_zero == $past(d0))
        else $error("output 0 source wrong");
    data1_route_a: assert property ($past(nrst) && !out1_silenced |-> serial_out_one == $past(d1))
        else $error("output 1 source wrong");
    quiet0_low_a: assert property (out0_silenced |-> !serial_out_zero)
        else $error("muted output 0 not low");
    quiet1_low_a: assert property (out1_silenced |-> !serial_out_one)
        else $error("muted output 1 not low");
    swing_track_a: assert property ($past(nrst) |-> out0_mute_latch_swing == $past(sw_r))
        else $error("swing output wrong");
    ctrl_readback_a: assert property (reg_rd && reg_addr == OMSC_ADDR_MUTE_CTRL |=> reg_rdata == $past(mc_r))
        else $error("mute control read wrong");
endmodule : omsc_chk
bind omsc_top omsc_chk i_omsc_chk (.*);

// file: dv/omsc_rx_model.sv
// Downstream receiver model: counts high bits seen on one output.
// Assumes the trace line is sampled on mclk; it never drives back.
`timescale 1ns/1ps
module omsc_rx_model
(
    input  wire logic        mclk,
    input  wire logic        din,
    output logic      [15:0] ones
);
    // Count only; a muted line must add nothing
    initial ones = 16'h0000;
    always @(posedge mclk)
        ones <= ones + 16'(din);
endmodule : omsc_rx_model

// file: dv/output_mute_select_control_tb.sv
// Bench for the output mute/select bank: table of control cases.
// Assumes the register port of omsc_top and one 40 MHz clock.
`timescale 1ns/1ps
module output_mute_select_control_tb
    import omsc_pkg::*;
;
    logic        mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        retimed_bit = 1'b0, prbs_bit = 1'b0, signal_lost = 1'b0, cdr_locked = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, ones0, ones1, snap;
    logic        serial_out_zero, serial_out_one, out0_silenced, out1_silenced;
    logic [5:0]  out0_mute_latch_swing;
    int          num_errors = 0, n_checks = 0, cyc = 0;
    logic [15:0] rst_val [7] = '{OMSC_RST_MUTE_SWING, OMSC_RST_RESERVED_A_A, OMSC_RST_RESERVED_A_B, OMSC_RST_RESERVED_A_C,
                                 OMSC_RST_RESERVED_A_D, OMSC_RST_SRC_SEL, OMSC_RST_MUTE_CTRL};
    // Rows: select nibble, mute byte, {retimed,prbs,lost,locked}, {out0,out1,mute0,mute1}
    logic [19:0] rows [13] = '{20'h0009c, 20'hc0090, 20'hf005c, 20'h20058, 20'h10054, 20'h00296, 20'h00899,
                               20'h005b3, 20'h00f9c, 20'h03083, 20'h01086, 20'h02089, 20'h0309c};
    omsc_top i_omsc_top (.*);
    omsc_rx_model i_omsc_rx_model_0 (.mclk(mclk), .din(serial_out_zero), .ones(ones0));
    omsc_rx_model i_omsc_rx_model_1 (.mclk(mclk), .din(serial_out_one), .ones(ones1));
    // 25 ns clock
    initial forever #12.5 mclk = ~mclk;
    // Hang guard, well above the roughly 130 cycles needed
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(OMSC_ADDR_MUTE_SWING + 8'(i), rst_val[i]);
        chk(16'(out0_mute_latch_swing), 16'h0008);
        wr(8'h4a, 16'hffff);
        rd(8'h4a, 16'h0000);
        rd(8'h42, 16'h0000);
        // Full-scale swing, reserved low byte kept at its reset value
        wr(OMSC_ADDR_MUTE_SWING, 16'h3f50);
        rd(OMSC_ADDR_MUTE_SWING, 16'h3f50);
        chk(16'(out0_mute_latch_swing), 16'h003f);
        // Table rows; the last four switch unlock muting on
        foreach (rows[i])
        begin
            wr(OMSC_ADDR_SRC_SEL, {12'h010, rows[i][19:16]});
            wr(OMSC_ADDR_MUTE_CTRL, {8'h00, rows[i][15:8]});
            {retimed_bit, prbs_bit, signal_lost, cdr_locked} <= rows[i][7:4];
            repeat (3) @(posedge mclk);
            #1 chk({12'h000, serial_out_zero, serial_out_one, out0_silenced, out1_silenced}, 16'(rows[i][3:0]));
        end
        // Manual mute of both: receivers must see no more ones
        wr(OMSC_ADDR_MUTE_CTRL, 16'h000a);
        repeat (3) @(posedge mclk);
        #1 snap = ones0 + ones1;
        repeat (8) @(posedge mclk);
        #1 chk(ones0 + ones1, snap);
        conclude();
    end
endmodule : output_mute_select_control_tb
